// ### include/word_load_pkg.sv
package word_load_pkg;
  typedef enum logic [2:0] {
    OP_FP = 3'b000,
    OP_SECOND_COPROCESSOR = 3'b001,
    OP_UWORD = 3'b010,
    OP_LMERGE = 3'b011,
    OP_ULMERGE = 3'b100
  } load_op_e;

  typedef enum logic [2:0] {
    EXC_NONE = 3'b000,
    EXC_REFILL = 3'b001,
    EXC_INVALID = 3'b010,
    EXC_BUS = 3'b011,
    EXC_ADDR = 3'b100,
    EXC_RI = 3'b101,
    EXC_CPU = 3'b110,
    EXC_WATCH = 3'b111
  } exc_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_XLAT = 2'b01,
    S_MEM = 2'b10,
    S_RESP = 2'b11
  } state_e;

  // segment access modes reported by translation
  localparam logic [2:0] SEG_MAPPED_USER_SUPER_UNMAPPED_KERNEL_MODE = 3'h1;
  localparam logic [2:0] SEG_UNMAPPED_USER_SUPER_KERNEL_MODE = 3'h2;
  localparam logic [2:0] SEG_MAPPED_USER_SUPER_KERNEL_MODE = 3'h3;

  localparam logic [1:0] WB_GPR = 2'h0;
  localparam logic [1:0] WB_FPR = 2'h1;
  localparam logic [1:0] WB_SECOND_COPROCESSOR = 2'h2;
  localparam logic [1:0] BYTE_WORD = 2'h3;

  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_EXC = 8'h0C;
  localparam logic [7:0] ADDR_FAULT = 8'h10;

  localparam int CTRL_REV = 0;
  localparam int CTRL_MEMBE = 1;
  localparam int CTRL_COREBE = 2;
  localparam int CTRL_COP0 = 3;
  localparam int CTRL_FPU = 4;
  localparam int CTRL_SECOND_COPROCESSOR = 5;
  localparam int CTRL_EVA = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0006;

  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAULT = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### include/merge_if.sv
`timescale 1ns/10ps
interface merge_if;
  import word_load_pkg::*;
  load_op_e op;
  logic [1:0] byte_idx;
  logic [31:0] mem_word;
  logic [31:0] dest_word;
  logic [31:0] result;
  modport unit (input op, byte_idx, mem_word, dest_word, output result);
  modport core (output op, byte_idx, mem_word, dest_word, input result);
endinterface

// ### logic/load_format.sv
`timescale 1ns/10ps
module load_format
  import word_load_pkg::*;
(
  // operands and merged word
  merge_if.unit mg
);
  logic [31:0] merged;

  // lane i takes memory lane (i+byte-3) once that index is non-negative
  for (genvar i = 0; i < 4; i++)
  begin : g_lane
    logic [2:0] k;
    logic [1:0] sel;
    assign k = 3'(i) + {1'b0, mg.byte_idx};
    assign sel = k[1:0] + 2'h1;
    assign merged[8*i +: 8] = (k >= 3'h3) ? mg.mem_word[{sel, 3'h0} +: 8]
                                          : mg.dest_word[8*i +: 8];
  end

  always_comb
  begin
    case (mg.op)
      OP_LMERGE, OP_ULMERGE: mg.result = merged;
      default: mg.result = mg.mem_word;
    endcase
  end
endmodule // load_format

// ### logic/word_load_unit.sv
`timescale 1ns/10ps
module word_load_unit
  import word_load_pkg::*;
#(
  parameter int XLEN = 32,
  parameter int PA_W = 32
)
(
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // register bus
  input logic [ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  output logic irq,
  // load request from the pipeline
  input logic req_valid,
  output logic req_ready,
  input load_op_e req_op,
  input logic [31:0] req_base,
  input logic [15:0] req_imm,
  input logic [31:0] req_dest,
  // address translation
  output logic xlat_valid,
  input logic xlat_ready,
  output logic [31:0] xlat_vaddr,
  output logic xlat_user,
  input logic [PA_W-1:0] xlat_paddr,
  input logic [2:0] xlat_seg_mode,
  input logic xlat_refill,
  input logic xlat_invalid,
  input logic xlat_watch,
  // data memory read
  output logic mem_valid,
  input logic mem_ready,
  output logic [PA_W-1:0] mem_paddr,
  output logic [1:0] mem_byte,
  input logic [31:0] mem_rdata,
  input logic mem_bus_err,
  // write-back and exception
  output logic wb_valid,
  output logic [1:0] wb_target,
  output logic [XLEN-1:0] wb_data,
  output logic exc_valid,
  output exc_e exc_code
);
  state_e state;
  load_op_e op_reg;
  exc_e early_code, xcode;
  logic [31:0] ctrl_reg, vaddr_reg, dest_reg, fault_vaddr_reg;
  logic [PA_W-1:0] paddr_reg;
  logic [1:0] byte_reg, plow;
  logic [XLEN-1:0] wb_data_reg;
  logic [1:0] wb_target_reg;
  logic [2:0] last_code_reg;
  logic [IRQ_W-1:0] status_reg, mask_reg, st_set, st_clr;
  logic [31:0] sext16, sext9, ea, word;
  logic is_user, merge_req, merge_reg, user_reg, seg_ok;

  merge_if fmt();

  load_format u_fmt (
    .mg(fmt.unit)
  );

  assign fmt.op = op_reg;
  assign fmt.byte_idx = byte_reg;
  assign fmt.mem_word = mem_rdata;
  assign fmt.dest_word = dest_reg;
  assign word = fmt.result;

  assign is_user = (req_op == OP_UWORD) || (req_op == OP_ULMERGE);
  assign merge_req = (req_op == OP_LMERGE) || (req_op == OP_ULMERGE);
  assign merge_reg = (op_reg == OP_LMERGE) || (op_reg == OP_ULMERGE);
  assign user_reg = (op_reg == OP_UWORD) || (op_reg == OP_ULMERGE);
  assign sext16 = {{16{req_imm[15]}}, req_imm};
  assign sext9 = {{23{req_imm[8]}}, req_imm[8:0]};
  assign ea = req_base + (is_user ? sext9 : sext16);

  // checks that need no translation, highest priority first
  always_comb
  begin
    early_code = EXC_NONE;
    if (!(req_op inside {OP_FP, OP_SECOND_COPROCESSOR, OP_UWORD, OP_LMERGE, OP_ULMERGE}))
      early_code = EXC_RI;
    else if (is_user && !ctrl_reg[CTRL_EVA])
      early_code = EXC_RI;
    else if ((is_user && !ctrl_reg[CTRL_COP0]) ||
             (req_op == OP_FP && !ctrl_reg[CTRL_FPU]) ||
             (req_op == OP_SECOND_COPROCESSOR && !ctrl_reg[CTRL_SECOND_COPROCESSOR]))
      early_code = EXC_CPU;
    else if (!merge_req && ea[1:0] != 2'h0)
      early_code = EXC_ADDR;
  end

  assign seg_ok = (xlat_seg_mode == SEG_MAPPED_USER_SUPER_UNMAPPED_KERNEL_MODE) ||
                  (xlat_seg_mode == SEG_UNMAPPED_USER_SUPER_KERNEL_MODE) ||
                  (xlat_seg_mode == SEG_MAPPED_USER_SUPER_KERNEL_MODE);

  // faults known once translation answers
  always_comb
  begin
    xcode = EXC_NONE;
    if (user_reg && !seg_ok)
      xcode = EXC_CPU;
    else if (xlat_refill)
      xcode = EXC_REFILL;
    else if (xlat_invalid)
      xcode = EXC_INVALID;
    else if (xlat_watch)
      xcode = EXC_WATCH;
  end

  // merge loads steer the byte lane by the byte-order flags
  always_comb
  begin
    plow = xlat_paddr[1:0] ^ {2{ctrl_reg[CTRL_REV]}};
    if (!ctrl_reg[CTRL_MEMBE])
      plow = 2'h0;
  end

  // sequencer and datapath
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= S_IDLE;
      op_reg <= OP_FP;
      exc_code <= EXC_NONE;
      vaddr_reg <= 32'h0;
      dest_reg <= 32'h0;
      paddr_reg <= '0;
      byte_reg <= 2'h0;
      wb_data_reg <= '0;
      wb_target_reg <= WB_GPR;
    end
    else
    begin
      case (state)
        S_IDLE:
          if (req_valid)
          begin
            op_reg <= req_op;
            vaddr_reg <= ea;
            dest_reg <= req_dest;
            byte_reg <= merge_req ? ea[1:0] ^ {2{ctrl_reg[CTRL_COREBE]}}
                                  : BYTE_WORD;
            exc_code <= early_code;
            state <= (early_code == EXC_NONE) ? S_XLAT : S_RESP;
          end
        S_XLAT:
          if (xlat_ready)
          begin
            paddr_reg <= merge_reg ? {xlat_paddr[PA_W-1:2], plow}
                                   : xlat_paddr;
            exc_code <= xcode;
            // a translation fault skips the read entirely
            state <= (xcode == EXC_NONE) ? S_MEM : S_RESP;
          end
        S_MEM:
          if (mem_ready)
          begin
            exc_code <= mem_bus_err ? EXC_BUS : EXC_NONE;
            case (op_reg)
              OP_FP:
              begin
                wb_target_reg <= WB_FPR;
                wb_data_reg <= XLEN'(word);
              end
              OP_SECOND_COPROCESSOR:
              begin
                wb_target_reg <= WB_SECOND_COPROCESSOR;
                wb_data_reg <= XLEN'(word);
              end
              default:
              begin
                wb_target_reg <= WB_GPR;
                wb_data_reg <= XLEN'($signed(word));
              end
            endcase
            state <= S_RESP;
          end
        S_RESP:
          state <= S_IDLE;
        default:
          state <= S_IDLE;
      endcase
    end
  end

  assign req_ready = (state == S_IDLE);
  assign xlat_valid = (state == S_XLAT);
  assign xlat_vaddr = vaddr_reg;
  assign xlat_user = user_reg;
  assign mem_valid = (state == S_MEM);
  assign mem_paddr = paddr_reg;
  assign mem_byte = byte_reg;
  // destination only written when nothing went wrong
  assign wb_valid = (state == S_RESP) && (exc_code == EXC_NONE);
  assign exc_valid = (state == S_RESP) && (exc_code != EXC_NONE);
  assign wb_data = wb_data_reg;
  assign wb_target = wb_target_reg;

  // fault capture for software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      last_code_reg <= 3'h0;
      fault_vaddr_reg <= 32'h0;
    end
    else if (exc_valid)
    begin
      last_code_reg <= exc_code;
      fault_vaddr_reg <= vaddr_reg;
    end
  end

  // register bus: write side
  logic aw_held, w_held, wr_en;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg, wmask;
  logic [3:0] wstrb_reg;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_en = aw_held && w_held && !s_axi_bvalid;
  assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                  {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_en)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg inside {ADDR_CTRL, ADDR_STATUS, ADDR_MASK,
                        ADDR_EXC, ADDR_FAULT}) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // writable control and mask
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= '0;
    end
    else if (wr_en)
    begin
      if (awaddr_reg == ADDR_CTRL)
        ctrl_reg <= (ctrl_reg & ~wmask) | (wdata_reg & wmask);
      if (awaddr_reg == ADDR_MASK)
        mask_reg <= (mask_reg & ~wmask[IRQ_W-1:0]) |
                    (wdata_reg[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
    end
  end

  // sticky events; a new event beats a same-cycle clear
  always_comb
  begin
    st_set = '0;
    st_set[IRQ_DONE] = wb_valid;
    st_set[IRQ_FAULT] = exc_valid;
    st_clr = '0;
    if (wr_en && awaddr_reg == ADDR_STATUS)
      st_clr = wdata_reg[IRQ_W-1:0] & wmask[IRQ_W-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_reg <= '0;
    else
      status_reg <= (status_reg & ~st_clr) | st_set;
  end

  assign irq = |(status_reg & mask_reg);

  // register bus: read side
  logic [31:0] rd_mux;
  logic rd_err;

  always_comb
  begin
    rd_err = 1'b0;
    case (s_axi_araddr)
      ADDR_CTRL: rd_mux = ctrl_reg;
      ADDR_STATUS: rd_mux = 32'(status_reg);
      ADDR_MASK: rd_mux = 32'(mask_reg);
      ADDR_EXC: rd_mux = {27'h0, state, last_code_reg};
      ADDR_FAULT: rd_mux = fault_vaddr_reg;
      default:
      begin
        rd_mux = 32'h0;
        rd_err = 1'b1;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_take_user;
    req_valid && req_ready && (req_op == OP_UWORD || req_op == OP_ULMERGE);
  endsequence

  sequence s_read_ok;
    mem_valid && mem_ready && !mem_bus_err;
  endsequence

  a_eva_absent: assert property (s_take_user ##0 !ctrl_reg[CTRL_EVA] |=>
    exc_valid && exc_code == EXC_RI)
    else $error("user load without enhanced addressing not reserved");
  a_cop0_off: assert property (s_take_user ##0 ctrl_reg[CTRL_EVA] &&
    !ctrl_reg[CTRL_COP0] |=> exc_valid && exc_code == EXC_CPU)
    else $error("user load with system coprocessor off not unusable");
  a_word_align: assert property (req_valid && req_ready &&
    (req_op == OP_FP || req_op == OP_SECOND_COPROCESSOR) && ctrl_reg[CTRL_FPU] &&
    ctrl_reg[CTRL_SECOND_COPROCESSOR] && (req_base[1:0] + req_imm[1:0]) != 2'h0 |=>
    exc_valid && exc_code == EXC_ADDR)
    else $error("misaligned coprocessor load not faulted");
  a_user_align: assert property (req_valid && req_ready &&
    req_op == OP_UWORD && ctrl_reg[CTRL_EVA] && ctrl_reg[CTRL_COP0] &&
    (req_base[1:0] + req_imm[1:0]) != 2'h0 |=>
    exc_valid && exc_code == EXC_ADDR)
    else $error("misaligned user word load not faulted");
  a_ea_sixteen: assert property (req_valid && req_ready && !is_user &&
    early_code == EXC_NONE |=> xlat_valid && !xlat_user &&
    xlat_vaddr == $past(req_base) + $past(sext16))
    else $error("effective address with 16-bit offset wrong");
  a_ea_nine: assert property (s_take_user ##0 early_code == EXC_NONE |=>
    xlat_valid && xlat_user &&
    xlat_vaddr == $past(req_base) + $past(sext9))
    else $error("effective address with 9-bit offset wrong");
  a_le_paddr: assert property (mem_valid && merge_reg &&
    !ctrl_reg[CTRL_MEMBE] |-> mem_paddr[1:0] == 2'h0)
    else $error("little-endian merge address low bits not cleared");
  a_fault_nowb: assert property (xlat_valid && xlat_ready && xlat_refill &&
    !user_reg |=> exc_valid && !wb_valid && exc_code == EXC_REFILL ##1
    !mem_valid)
    else $error("refill fault wrote back or read memory");
  a_fp_low: assert property (s_read_ok ##0 op_reg == OP_FP |=>
    wb_valid && wb_target == WB_FPR && wb_data[31:0] == $past(mem_rdata))
    else $error("float load word not delivered");
  a_sign_ext: assert property (s_read_ok ##0 op_reg == OP_UWORD |=> wb_valid
    && wb_data == XLEN'($signed($past(mem_rdata))))
    else $error("user word load result not sign-extended");
  a_full_merge: assert property (s_read_ok ##0 merge_reg &&
    mem_byte == 2'h3 |=> wb_valid && wb_data[31:0] == $past(mem_rdata))
    else $error("merge at byte three did not copy the whole word");
  a_merge_keep: assert property (s_read_ok ##0 merge_reg &&
    mem_byte == 2'h0 |=> wb_valid && wb_data[23:0] == dest_reg[23:0])
    else $error("merge at byte zero lost low destination bytes");
endmodule // word_load_unit

// ### tb/xlat_mem_model.sv
`timescale 1ns/10ps
module xlat_mem_model
  import word_load_pkg::*;
(
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // behaviour chosen by the bench
  input logic [2:0] seg_cfg,
  input logic [2:0] flt_cfg,
  input logic [1:0] dly_cfg,
  input logic [31:0] word_cfg,
  // translation
  input logic xlat_valid,
  output logic xlat_ready,
  input logic [31:0] xlat_vaddr,
  output logic [31:0] xlat_paddr,
  output logic [2:0] xlat_seg_mode,
  output logic xlat_refill,
  output logic xlat_invalid,
  output logic xlat_watch,
  // data memory
  input logic mem_valid,
  output logic mem_ready,
  output logic [31:0] mem_rdata,
  output logic mem_bus_err
);
  logic [1:0] xw, mw;
  // each answer comes after dly_cfg + 1 cycles of waiting
  always_ff @(posedge aclk)
  begin
    xw <= (xlat_valid && !xlat_ready) ? xw + 2'h1 : 2'h0;
    mw <= (mem_valid && !mem_ready) ? mw + 2'h1 : 2'h0;
    xlat_ready <= aresetn && xlat_valid && !xlat_ready && xw == dly_cfg;
    mem_ready <= aresetn && mem_valid && !mem_ready && mw == dly_cfg;
  end
  // outside the answer cycle the lines show junk, never the old answer
  assign xlat_paddr = xlat_ready ? xlat_vaddr : ~xlat_vaddr;
  assign xlat_seg_mode = xlat_ready ? seg_cfg : ~seg_cfg;
  assign xlat_refill = xlat_ready ? flt_cfg == 3'h1 : 1'b1;
  assign xlat_invalid = xlat_ready ? flt_cfg == 3'h2 : 1'b1;
  assign xlat_watch = xlat_ready ? flt_cfg == 3'h3 : 1'b1;
  assign mem_rdata = mem_ready ? word_cfg : ~word_cfg;
  assign mem_bus_err = mem_ready ? flt_cfg == 3'h4 : 1'b1;
endmodule // xlat_mem_model

// ### tb/word_load_unit_tb.sv
`timescale 1ns/10ps
module word_load_unit_tb;
  import word_load_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp, mem_byte, wb_target;
  logic req_valid, req_ready, xlat_valid, xlat_ready, xlat_user;
  logic xlat_refill, xlat_invalid, xlat_watch, mem_valid, mem_ready;
  logic mem_bus_err, wb_valid, exc_valid, got_wb, got_exc, seen_user;
  load_op_e req_op;
  exc_e exc_code;
  logic [15:0] req_imm;
  logic [31:0] req_base, req_dest, xlat_vaddr, xlat_paddr, mem_paddr;
  logic [31:0] mem_rdata, wb_data, word_cfg, seen_va, seen_pa, mem_reads;
  logic [2:0] xlat_seg_mode, seg_cfg, flt_cfg;
  logic [1:0] dly_cfg, seen_byte;
  int bad_count, check_count;

  word_load_unit dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq, .req_valid, .req_ready, .req_op, .req_base, .req_imm, .req_dest,
    .xlat_valid, .xlat_ready, .xlat_vaddr, .xlat_user, .xlat_paddr,
    .xlat_seg_mode, .xlat_refill, .xlat_invalid, .xlat_watch, .mem_valid,
    .mem_ready, .mem_paddr, .mem_byte, .mem_rdata, .mem_bus_err, .wb_valid,
    .wb_target, .wb_data, .exc_valid, .exc_code);

  xlat_mem_model model_u (.aclk, .aresetn, .seg_cfg, .flt_cfg, .dly_cfg,
    .word_cfg, .xlat_valid, .xlat_ready, .xlat_vaddr, .xlat_paddr,
    .xlat_seg_mode, .xlat_refill, .xlat_invalid, .xlat_watch, .mem_valid,
    .mem_ready, .mem_rdata, .mem_bus_err);

  always #50 aclk = ~aclk;

  always @(posedge aclk)
  begin
    if (xlat_valid && xlat_ready) seen_va <= xlat_vaddr;
    if (xlat_valid && xlat_ready) seen_user <= xlat_user;
    if (mem_valid && mem_ready) seen_pa <= mem_paddr;
    if (mem_valid && mem_ready) seen_byte <= mem_byte;
    if (mem_valid && mem_ready) mem_reads <= mem_reads + 32'h1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic hung();
    bad_count++;
    $display("BAD %0t no answer", $time);
    complete_run();
  endtask

  // address and data offered together, each released once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int i;
    logic aw, wd, bd;
    i = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      wd = s_axi_wvalid && s_axi_wready;
      bd = s_axi_bvalid;
      wr_resp = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
      if (bd) s_axi_bready <= 1'b0;
      if (++i > 50) hung();
    end while (!bd);
  endtask

  task automatic axr(input logic [7:0] a);
    int i;
    logic ar, rd;
    i = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      rd = s_axi_rvalid;
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (rd) s_axi_rready <= 1'b0;
      if (++i > 50) hung();
    end while (!rd);
  endtask

  task automatic ld(input load_op_e op, input logic [31:0] base,
    input logic [15:0] imm, input logic [31:0] dest);
    int i;
    logic tk;
    i = 0;
    got_wb = 1'b0;
    got_exc = 1'b0;
    @(posedge aclk);
    req_op <= op;
    req_base <= base;
    req_imm <= imm;
    req_dest <= dest;
    req_valid <= 1'b1;
    do
    begin
      @(negedge aclk);
      tk = req_valid && req_ready;
      if (wb_valid) got_wb = 1'b1;
      if (exc_valid) got_exc = 1'b1;
      @(posedge aclk);
      if (tk) req_valid <= 1'b0;
      if (++i > 60) hung();
    end while (!(got_wb || got_exc));
  endtask

  task automatic want_wb(input logic [1:0] tgt, input logic [31:0] d);
    chk(32'(got_exc), 32'h0);
    chk(32'(got_wb), 32'h1);
    chk(32'(wb_target), 32'(tgt));
    chk(wb_data, d);
  endtask

  task automatic want_exc(input exc_e code);
    chk(32'(got_wb), 32'h0);
    chk(32'(got_exc), 32'h1);
    chk(32'(exc_code), 32'(code));
  endtask

  task automatic t_regs();
    axr(ADDR_CTRL);
    chk(rd_data, CTRL_RESET);
    axr(8'h40);
    chk(32'(rd_resp), 32'(RESP_SLVERR));
    chk(rd_data, 32'h0);
    axw(8'h40, 32'h7E);
    chk(32'(wr_resp), 32'(RESP_SLVERR));
    axw(ADDR_CTRL, 32'h7E);
    chk(32'(wr_resp), 32'(RESP_OKAY));
    axr(ADDR_CTRL);
    chk(rd_data, 32'h7E);
    // low lane masked off: a write that ignored strobes would clear it
    s_axi_wstrb <= 4'hE;
    axw(ADDR_CTRL, 32'h0);
    s_axi_wstrb <= 4'hF;
    axr(ADDR_CTRL);
    chk(rd_data, 32'h7E);
    $display("test regs done");
  endtask

  task automatic t_word();
    word_cfg <= 32'hA5C3_0F11;
    ld(OP_FP, 32'h1000, 16'hFFFC, 32'h0);
    want_wb(WB_FPR, 32'hA5C3_0F11);
    chk(seen_va, 32'h0FFC);
    dly_cfg <= 2'h3;
    ld(OP_SECOND_COPROCESSOR, 32'h2000, 16'h0010, 32'h0);
    want_wb(WB_SECOND_COPROCESSOR, 32'hA5C3_0F11);
    chk(seen_va, 32'h2010);
    dly_cfg <= 2'h0;
    word_cfg <= 32'h8000_0001;
    ld(OP_UWORD, 32'h0100, 16'h01FC, 32'h0);
    want_wb(WB_GPR, 32'h8000_0001);
    chk(seen_va, 32'h00FC);
    chk(32'(seen_user), 32'h1);
    $display("test word done");
  endtask

  task automatic t_align();
    logic [31:0] n;
    n = mem_reads;
    ld(OP_SECOND_COPROCESSOR, 32'h1001, 16'h0, 32'h0);
    want_exc(EXC_ADDR);
    ld(OP_FP, 32'h1000, 16'h0002, 32'h0);
    want_exc(EXC_ADDR);
    ld(OP_UWORD, 32'h0100, 16'h0003, 32'h0);
    want_exc(EXC_ADDR);
    chk(mem_reads, n);
    $display("test align done");
  endtask

  task automatic t_user();
    int s;
    for (s = 1; s < 4; s++)
    begin
      seg_cfg <= 3'(s);
      ld(OP_UWORD, 32'h0100, 16'h0, 32'h0);
      want_wb(WB_GPR, 32'h8000_0001);
    end
    seg_cfg <= 3'h0;
    ld(OP_UWORD, 32'h0100, 16'h0, 32'h0);
    want_exc(EXC_CPU);
    seg_cfg <= SEG_MAPPED_USER_SUPER_UNMAPPED_KERNEL_MODE;
    axw(ADDR_CTRL, 32'h76);
    ld(OP_ULMERGE, 32'h0100, 16'h0, 32'h0);
    want_exc(EXC_CPU);
    axw(ADDR_CTRL, 32'h3E);
    ld(OP_UWORD, 32'h0100, 16'h0, 32'h0);
    want_exc(EXC_RI);
    $display("test user done");
  endtask

  task automatic t_merge();
    logic [31:0] cfg, e;
    logic [1:0] b, pl;
    int c, o, sh;
    word_cfg <= 32'hAABB_CCDD;
    for (c = 0; c < 4; c++)
    begin
      cfg = c == 0 ? 32'h7A : c == 1 ? 32'h7E : c == 2 ? 32'h7F : 32'h7D;
      axw(ADDR_CTRL, cfg);
      for (o = 0; o < 4; o++)
      begin
        b = 2'(o) ^ {2{cfg[CTRL_COREBE]}};
        sh = 24 - 8 * int'(b);
        e = (32'hAABB_CCDD << sh) | (32'h1122_3344 & ((32'h1 << sh) - 1));
        pl = cfg[CTRL_MEMBE] ? 2'(o) ^ {2{cfg[CTRL_REV]}} : 2'h0;
        ld(c[0] ? OP_ULMERGE : OP_LMERGE, 32'h200 + o, 16'h0, 32'h1122_3344);
        want_wb(WB_GPR, e);
        chk(32'(seen_byte), 32'(b));
        chk(32'(seen_pa[1:0]), 32'(pl));
        chk(seen_va, 32'h200 + o);
      end
    end
    $display("test merge done");
  endtask

  task automatic t_faults();
    exc_e fx [1:4] = '{EXC_REFILL, EXC_INVALID, EXC_WATCH, EXC_BUS};
    int f;
    axw(ADDR_CTRL, 32'h7E);
    axw(ADDR_STATUS, 32'h3);
    axw(ADDR_MASK, 32'h2);
    @(negedge aclk);
    chk(32'(irq), 32'h0);
    for (f = 1; f < 5; f++)
    begin
      flt_cfg <= 3'(f);
      ld(OP_LMERGE, 32'h300, 16'h0001, 32'h0);
      want_exc(fx[f]);
    end
    flt_cfg <= 3'h1;
    ld(OP_SECOND_COPROCESSOR, 32'h300, 16'h0, 32'h0);
    want_exc(EXC_REFILL);
    flt_cfg <= 3'h3;
    ld(OP_FP, 32'h300, 16'h0, 32'h0);
    want_exc(EXC_WATCH);
    flt_cfg <= 3'h0;
    @(negedge aclk);
    chk(32'(irq), 32'h1);
    axr(ADDR_STATUS);
    chk(rd_data & 32'h2, 32'h2);
    axr(ADDR_FAULT);
    chk(rd_data, 32'h300);
    axr(ADDR_EXC);
    chk(rd_data, 32'(EXC_WATCH));
    axw(ADDR_STATUS, 32'h2);
    @(negedge aclk);
    chk(32'(irq), 32'h0);
    $display("test faults done");
  endtask

  task automatic t_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(ADDR_CTRL);
    chk(rd_data, CTRL_RESET);
    axr(ADDR_MASK);
    chk(rd_data, 32'h0);
    @(negedge aclk);
    chk(32'(irq), 32'h0);
    $display("test reset done");
  endtask

  initial
  begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, req_valid, req_base, req_imm} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, req_dest} = '0;
    {flt_cfg, dly_cfg, word_cfg, mem_reads} = '0;
    s_axi_wstrb = 4'hF;
    req_op = OP_FP;
    seg_cfg = SEG_MAPPED_USER_SUPER_UNMAPPED_KERNEL_MODE;
    bad_count = 0;
    check_count = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_word();
    t_align();
    t_user();
    t_merge();
    t_faults();
    t_reset();
    complete_run();
  end
endmodule // word_load_unit_tb
